// file: design/scs_clock_select.sv
// Contract
// [R1] Instruction clock is processor clock divided by two.
// [R2] Times-four PLL serves only primary oscillator or 8 MHz fast RC.
// [R3] Fast RC may pass a programmable postscaler before use.
// [R4] Instruction clock may drive the primary output pin in some primary modes.
// [R5] Output pin function chosen by a dedicated configuration bit.
// [R6] At power-on, source chosen by 2-bit mode and 3-bit initial fields.
// [R7] Erased fields 11/111 select 8 MHz fast RC with postscaler.
// [R8] 110 selects 500 kHz fast RC postscaled, 101 low-power RC, mode 11.
// [R9] 001 selects fast RC through PLL, 000 plain fast RC.
// [R10] 100 with mode 00 selects the secondary oscillator.
// [R11] 011 runs primary through PLL: mode 10 crystal, 00 external clock.
// [R12] 010 runs primary plain: 10 fast crystal, 01 standard, 00 external.
// [R13] 2-bit range field tunes external clock mode; erased means above 8 MHz.
// [R14] Run-time switching allowed only when upper switch/monitor bit is zero.
// [R15] Fail-safe monitor enabled only when both switch/monitor bits are zero.
// [R16] One bit selects high- or low-power secondary oscillator.
// [R17] Low-power RC runs high-accuracy or low-power mode.
// [R18] Fast RC exists as 8 MHz and 500 kHz variants.
// [R19] Processor and peripheral clocks come from the one selected source.
// [R20] Fields sampled once after reset; selection held until reset or switch.
module scs_clock_select (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [12:0]           osc_source_config_word,
	input  wire logic                  primary_osc_in_pin,
	input  wire logic                  secondary_osc_in_pin,
	output logic                       primary_osc_out_pin_o,
	output logic                       primary_osc_out_pin_oe_n,
	output scs_pkg::scs_osc_ctrl_t     osc_ctrl,
	output logic                       cpu_clk_en,
	output logic                       periph_clk_en,
	output logic                       instr_clk_en
);
	import scs_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] pri_sync_q;
	logic [1:0] sec_sync_q;
	logic       pri_prev_q;
	logic       sec_prev_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pri_sync_q <= 2'h0;
			sec_sync_q <= 2'h0;
			pri_prev_q <= 1'b0;
			sec_prev_q <= 1'b0;
		end else begin
			pri_sync_q <= {pri_sync_q[0], primary_osc_in_pin};
			sec_sync_q <= {sec_sync_q[0], secondary_osc_in_pin};
			pri_prev_q <= pri_sync_q[1];
			sec_prev_q <= sec_sync_q[1];
		end
	end

	logic pri_tick;
	logic sec_tick;
	assign pri_tick = pri_sync_q[1] & ~pri_prev_q;
	assign sec_tick = sec_sync_q[1] & ~sec_prev_q;

	// ----------------------------------------------------------------
	// Configuration capture after reset release
	// ----------------------------------------------------------------
	// Straps are caught by a clocked load, never by the async reset
	scs_cfg_t cfg_q;
	logic     cfg_loaded_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_loaded_q <= 1'b0;
			cfg_q        <= '{SCS_PMODE_ERASED, SCS_INIT_ERASED, SCS_RANGE_ERASED,
			                  SCS_SWMON_ERASED, 1'b1, 1'b1, 1'b1}; // [R7] [R13]
		end else if (!cfg_loaded_q) begin
			cfg_loaded_q <= 1'b1; // [R20]
			cfg_q.primary_mode_field       <= osc_source_config_word[SCS_PMODE_LSB +: 2]; // [R6]
			cfg_q.initial_source_field     <= osc_source_config_word[SCS_INIT_LSB +: 3]; // [R6]
			cfg_q.ext_clock_range_field    <= osc_source_config_word[SCS_RANGE_LSB +: 2];
			cfg_q.switch_monitor_field     <= osc_source_config_word[SCS_SWMON_LSB +: 2];
			cfg_q.secondary_power_select   <= osc_source_config_word[SCS_SECPWR_BIT];
			cfg_q.osc_out_pin_function_bit <= osc_source_config_word[SCS_OUTFN_BIT];
			cfg_q.low_power_internal_rc_low_power           <= osc_source_config_word[SCS_LOW_POWER_INTERNAL_RC_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Source decode
	// ----------------------------------------------------------------
	function automatic scs_src_t decode_src(input logic [2:0] init, input logic [1:0] pmode);
		scs_src_t s;
		s = SCS_SRC_INVALID;
		case (init)
			SCS_INIT_FRC_DIV:  s = SCS_SRC_FRC_DIV;  // [R7]
			SCS_INIT_SLOW_FRC: s = SCS_SRC_SLOW_FRC; // [R8]
			SCS_INIT_LOW_POWER_INTERNAL_RC:     s = SCS_SRC_LOW_POWER_INTERNAL_RC;     // [R8]
			SCS_INIT_SEC:      s = SCS_SRC_SEC;      // [R10]
			SCS_INIT_FRC_PLL:  s = SCS_SRC_FRC_PLL;  // [R9]
			SCS_INIT_FRC:      s = SCS_SRC_FRC;      // [R9]
			SCS_INIT_PRI_PLL: begin
				if (pmode == SCS_PMODE_HS)
					s = SCS_SRC_HS_PLL; // [R11]
				else if (pmode == SCS_PMODE_EXT)
					s = SCS_SRC_EXT_PLL; // [R11]
				else
					s = SCS_SRC_INVALID;
			end
			SCS_INIT_PRI: begin
				case (pmode)
					SCS_PMODE_HS:  s = SCS_SRC_HS;  // [R12]
					SCS_PMODE_STD: s = SCS_SRC_STD; // [R12]
					SCS_PMODE_EXT: s = SCS_SRC_EXT; // [R12]
					default:       s = SCS_SRC_INVALID;
				endcase
			end
			default: s = SCS_SRC_INVALID;
		endcase
		return s;
	endfunction

	// Invalid combinations fall back to the 8 MHz fast RC so the core always has a clock
	scs_src_t boot_src;
	scs_src_t boot_src_safe;
	assign boot_src      = decode_src(cfg_q.initial_source_field, cfg_q.primary_mode_field);
	assign boot_src_safe = (boot_src == SCS_SRC_INVALID) ? SCS_SRC_FRC : boot_src;

	// ----------------------------------------------------------------
	// Register file and run-time switch
	// ----------------------------------------------------------------
	logic       switch_allowed;
	logic       monitor_on;
	assign switch_allowed = ~cfg_q.switch_monitor_field[1];              // [R14]
	assign monitor_on     = (cfg_q.switch_monitor_field == 2'h0);        // [R15]

	logic       access;
	logic       wr_en;
	logic       addr_ok;
	assign access  = psel & penable;
	assign wr_en   = access & pwrite;
	assign addr_ok = (paddr == SCS_ADDR_CONFIG) || (paddr == SCS_ADDR_STATUS) ||
	                 (paddr == SCS_ADDR_SWITCH) || (paddr == SCS_ADDR_DIVIDER);

	scs_src_t   cur_src_q;
	logic       switch_refused_q;
	logic       switch_seen_q;
	logic [2:0] postdiv_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_src_q        <= SCS_SRC_FRC_DIV;
			switch_refused_q <= 1'b0;
		end else if (!cfg_loaded_q) begin
			cur_src_q <= SCS_SRC_FRC_DIV;
		end else if (!cfg_loaded_q || (cur_src_q != boot_src_safe && !switch_seen_q)) begin
			cur_src_q <= boot_src_safe; // [R6] [R20]
		end else if (wr_en && paddr == SCS_ADDR_SWITCH) begin
			if (switch_allowed && decode_src(pwdata[2:0], pwdata[9:8]) != SCS_SRC_INVALID) begin
				cur_src_q        <= decode_src(pwdata[2:0], pwdata[9:8]); // [R14]
				switch_refused_q <= 1'b0;
			end else begin
				switch_refused_q <= 1'b1;
			end
		end
	end

	// Marks that software has written a switch request while switching is allowed, even one that is refused
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			switch_seen_q <= 1'b0;
		else if (cfg_loaded_q && wr_en && paddr == SCS_ADDR_SWITCH && switch_allowed)
			switch_seen_q <= 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			postdiv_q <= SCS_POSTDIV_RESET;
		else if (wr_en && paddr == SCS_ADDR_DIVIDER)
			postdiv_q <= pwdata[2:0]; // [R3]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_ok;
			prdata  <= 32'h0;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					SCS_ADDR_CONFIG:  prdata <= {20'h0, cfg_q};
					SCS_ADDR_STATUS:  prdata <= {24'h0, switch_refused_q, monitor_on,
					                             switch_allowed, 1'b0, cur_src_q};
					SCS_ADDR_SWITCH:  prdata <= {28'h0, cur_src_q};
					SCS_ADDR_DIVIDER: prdata <= {29'h0, postdiv_q};
					default:          prdata <= 32'h0;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Oscillator controls
	// ----------------------------------------------------------------
	logic src_primary;
	logic src_pll;
	logic src_fast_rc;
	assign src_primary = cur_src_q inside {SCS_SRC_HS, SCS_SRC_STD, SCS_SRC_EXT,
	                                       SCS_SRC_HS_PLL, SCS_SRC_EXT_PLL};
	assign src_pll     = cur_src_q inside {SCS_SRC_FRC_PLL, SCS_SRC_HS_PLL, SCS_SRC_EXT_PLL}; // [R2]
	assign src_fast_rc = cur_src_q inside {SCS_SRC_FRC, SCS_SRC_FRC_PLL, SCS_SRC_FRC_DIV};  // [R18]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_ctrl <= '0;
		end else begin
			osc_ctrl.primary_osc_enable     <= src_primary;
			osc_ctrl.primary_high_gain      <= cur_src_q inside {SCS_SRC_HS, SCS_SRC_HS_PLL};
			osc_ctrl.primary_ext_clock      <= cur_src_q inside {SCS_SRC_EXT, SCS_SRC_EXT_PLL};
			osc_ctrl.ext_clock_range_field  <= cfg_q.ext_clock_range_field;   // [R13]
			osc_ctrl.secondary_osc_enable   <= (cur_src_q == SCS_SRC_SEC);
			osc_ctrl.secondary_power_select <= cfg_q.secondary_power_select;  // [R16]
			osc_ctrl.fast_rc_enable         <= src_fast_rc;                   // [R18]
			osc_ctrl.slow_fast_rc_enable    <= (cur_src_q == SCS_SRC_SLOW_FRC); // [R18]
			osc_ctrl.low_power_internal_rc_enable            <= (cur_src_q == SCS_SRC_LOW_POWER_INTERNAL_RC);
			osc_ctrl.low_power_internal_rc_low_power         <= cfg_q.low_power_internal_rc_low_power;          // [R17]
			osc_ctrl.pll_enable             <= src_pll;                       // [R2]
			osc_ctrl.postdiv                <= (cur_src_q inside {SCS_SRC_FRC_DIV, SCS_SRC_SLOW_FRC})
			                                   ? postdiv_q : SCS_POSTDIV_RESET; // [R3]
			osc_ctrl.failsafe_clock_monitor <= monitor_on;                    // [R15]
			osc_ctrl.switch_allowed         <= switch_allowed;                // [R14]
		end
	end

	// ----------------------------------------------------------------
	// Clock enable generation
	// ----------------------------------------------------------------
	// Internal sources are modelled as pclk rate; external ones as synchronised edges
	logic       src_tick;
	logic [1:0] pll_cnt_q;
	logic [7:0] post_cnt_q;
	logic       pre_tick;
	logic       proc_tick;

	assign src_tick = src_primary ? pri_tick : (cur_src_q == SCS_SRC_SEC) ? sec_tick : 1'b1;
	// PLL multiplies primary ticks by four; fast RC through it stays at one processor tick per pclk
	assign pre_tick  = src_pll ? (src_tick || pll_cnt_q != 2'h0) : src_tick; // [R2]
	assign proc_tick = pre_tick && (osc_ctrl.postdiv == SCS_POSTDIV_RESET ||
	                                post_cnt_q == 8'h0); // [R3]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pll_cnt_q <= 2'h0;
		else if (src_pll && (src_tick || pll_cnt_q != 2'h0))
			pll_cnt_q <= (pll_cnt_q == SCS_PLL_MULT) ? 2'h0 : pll_cnt_q + 2'h1;
		else
			pll_cnt_q <= 2'h0;
	end

	// Postscaler divides by 2^postdiv
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			post_cnt_q <= 8'h0;
		else if (pre_tick)
			post_cnt_q <= (post_cnt_q >= ((8'h1 << osc_ctrl.postdiv) - 8'h1)) ? 8'h0 : post_cnt_q + 8'h1;
	end

	logic cy_phase_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cy_phase_q    <= 1'b0;
			cpu_clk_en    <= 1'b0;
			periph_clk_en <= 1'b0;
			instr_clk_en  <= 1'b0;
		end else begin
			if (proc_tick)
				cy_phase_q <= ~cy_phase_q;
			cpu_clk_en    <= proc_tick;                // [R19]
			periph_clk_en <= proc_tick;                // [R19]
			instr_clk_en  <= proc_tick & cy_phase_q;   // [R1]
		end
	end

	// ----------------------------------------------------------------
	// Output pin function
	// ----------------------------------------------------------------
	// Only non-crystal sources free the pin; a crystal needs it for the resonator
	logic pin_drives_cy;
	assign pin_drives_cy = !cfg_q.osc_out_pin_function_bit &&
	                       !(cur_src_q inside {SCS_SRC_HS, SCS_SRC_STD, SCS_SRC_HS_PLL}); // [R4] [R5]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			primary_osc_out_pin_o    <= 1'b0;
			primary_osc_out_pin_oe_n <= 1'b1;
		end else begin
			primary_osc_out_pin_oe_n <= ~pin_drives_cy; // [R5]
			if (proc_tick)
				primary_osc_out_pin_o <= cy_phase_q;    // [R4]
		end
	end

endmodule

// file: design/scs_pkg.sv
package scs_pkg;

	// ----------------------------------------------------------------
	// Register map (APB byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] SCS_ADDR_CONFIG  = 8'h00;
	localparam logic [7:0] SCS_ADDR_STATUS  = 8'h04;
	localparam logic [7:0] SCS_ADDR_SWITCH  = 8'h08;
	localparam logic [7:0] SCS_ADDR_DIVIDER = 8'h0c;

	// ----------------------------------------------------------------
	// Configuration word layout
	// ----------------------------------------------------------------
	localparam int SCS_PMODE_LSB  = 0;
	localparam int SCS_RANGE_LSB  = 3;
	localparam int SCS_SECPWR_BIT = 5;
	localparam int SCS_SWMON_LSB  = 6;
	localparam int SCS_INIT_LSB   = 8;
	localparam int SCS_OUTFN_BIT  = 11;
	localparam int SCS_LOW_POWER_INTERNAL_RC_BIT   = 12;

	// Erased configuration values
	localparam logic [1:0] SCS_PMODE_ERASED = 2'h3;
	localparam logic [2:0] SCS_INIT_ERASED  = 3'h7;
	localparam logic [1:0] SCS_RANGE_ERASED = 2'h3;
	localparam logic [1:0] SCS_SWMON_ERASED = 2'h3;

	// Primary mode field encodings
	localparam logic [1:0] SCS_PMODE_EXT  = 2'h0;
	localparam logic [1:0] SCS_PMODE_STD  = 2'h1;
	localparam logic [1:0] SCS_PMODE_HS   = 2'h2;
	localparam logic [1:0] SCS_PMODE_OFF  = 2'h3;

	// Initial source field encodings
	localparam logic [2:0] SCS_INIT_FRC      = 3'h0;
	localparam logic [2:0] SCS_INIT_FRC_PLL  = 3'h1;
	localparam logic [2:0] SCS_INIT_PRI      = 3'h2;
	localparam logic [2:0] SCS_INIT_PRI_PLL  = 3'h3;
	localparam logic [2:0] SCS_INIT_SEC      = 3'h4;
	localparam logic [2:0] SCS_INIT_LOW_POWER_INTERNAL_RC     = 3'h5;
	localparam logic [2:0] SCS_INIT_SLOW_FRC = 3'h6;
	localparam logic [2:0] SCS_INIT_FRC_DIV  = 3'h7;

	localparam logic [2:0] SCS_POSTDIV_RESET = 3'h0;
	localparam logic [1:0] SCS_PLL_MULT      = 2'h3;

	typedef enum logic [3:0] {
		SCS_SRC_FRC,
		SCS_SRC_FRC_PLL,
		SCS_SRC_HS,
		SCS_SRC_STD,
		SCS_SRC_EXT,
		SCS_SRC_HS_PLL,
		SCS_SRC_EXT_PLL,
		SCS_SRC_SEC,
		SCS_SRC_LOW_POWER_INTERNAL_RC,
		SCS_SRC_SLOW_FRC,
		SCS_SRC_FRC_DIV,
		SCS_SRC_INVALID
	} scs_src_t;

	typedef struct packed {
		logic [1:0] primary_mode_field;
		logic [2:0] initial_source_field;
		logic [1:0] ext_clock_range_field;
		logic [1:0] switch_monitor_field;
		logic       secondary_power_select;
		logic       osc_out_pin_function_bit;
		logic       low_power_internal_rc_low_power;
	} scs_cfg_t;

	typedef struct packed {
		logic       primary_osc_enable;
		logic       primary_high_gain;
		logic       primary_ext_clock;
		logic [1:0] ext_clock_range_field;
		logic       secondary_osc_enable;
		logic       secondary_power_select;
		logic       fast_rc_enable;
		logic       slow_fast_rc_enable;
		logic       low_power_internal_rc_enable;
		logic       low_power_internal_rc_low_power;
		logic       pll_enable;
		logic [2:0] postdiv;
		logic       failsafe_clock_monitor;
		logic       switch_allowed;
	} scs_osc_ctrl_t;

endpackage

// file: tb/scs_osc_model.sv
module scs_osc_model #(
	parameter int HALF_NS = 16
) (
	output logic pin
);
	timeunit 1ns;
	timeprecision 100ps;

	// Free-running oscillator, phase unrelated to pclk
	initial begin
		pin = 1'b0;
		#1.3;
		forever begin
			#(HALF_NS) pin = !pin;
		end
	end
endmodule

// file: tb/scs_clock_select_checker.sv
module scs_clock_select_checker (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [7:0]             paddr,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic [12:0]            osc_source_config_word,
	input wire scs_pkg::scs_osc_ctrl_t osc_ctrl,
	input wire logic                   cpu_clk_en,
	input wire logic                   periph_clk_en,
	input wire logic                   instr_clk_en,
	input wire logic                   primary_osc_out_pin_oe_n
);
	import scs_pkg::*;
	logic [2:0] age_q;
	logic       ok;
	logic       cfg_wr;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	assign ok = (age_q == 3'h5);
	assign cfg_wr = psel && penable && pwrite && (paddr == SCS_ADDR_SWITCH || paddr == SCS_ADDR_DIVIDER);

	// Control outputs only settle a few edges after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) age_q <= 3'h0;
		else if (!ok) age_q <= age_q + 3'h1;
	end

	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable; endsequence
	property p_zero_wait; s_setup ##1 s_access |-> pready; endproperty
	property p_slverr; pslverr |-> pready; endproperty
	property p_instr; instr_clk_en |-> cpu_clk_en ##1 !instr_clk_en; endproperty
	property p_periph; cpu_clk_en == periph_clk_en; endproperty
	property p_pll; osc_ctrl.pll_enable |-> !osc_ctrl.secondary_osc_enable && !osc_ctrl.slow_fast_rc_enable; endproperty
	property p_switch; osc_ctrl.switch_allowed |-> !osc_source_config_word[7]; endproperty
	property p_monitor; osc_ctrl.failsafe_clock_monitor |-> osc_source_config_word[7:6] == 2'h0; endproperty
	property p_outfn; osc_source_config_word[11] |-> primary_osc_out_pin_oe_n; endproperty
	property p_fields;
		ok |-> osc_ctrl.ext_clock_range_field == osc_source_config_word[4:3]
			&& osc_ctrl.secondary_power_select == osc_source_config_word[5]
			&& osc_ctrl.low_power_internal_rc_low_power == osc_source_config_word[12];
	endproperty
	property p_hold;
		ok && !$stable(osc_ctrl) |-> $past(cfg_wr) || $past(cfg_wr, 2) || $past(cfg_wr, 3);
	endproperty

	a_zero_wait: assert property (p_zero_wait) else $error("pready missing in access cycle");
	a_slverr: assert property (p_slverr) else $error("pslverr outside answer");
	a_instr: assert property (p_instr) else $error("instruction tick off processor ticks");
	a_periph: assert property (p_periph) else $error("peripheral tick differs");
	a_pll: assert property (p_pll) else $error("pll on a barred source");
	a_switch: assert property (p_switch) else $error("switching allowed by config");
	a_monitor: assert property (p_monitor) else $error("monitor on by config");
	a_outfn: assert property (p_outfn) else $error("out pin driven while disabled");
	a_fields: assert property (p_fields) else $error("config field not passed");
	a_hold: assert property (p_hold) else $error("control changed without write");
endmodule

bind scs_clock_select scs_clock_select_checker chk_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pready(pready), .pslverr(pslverr), .osc_source_config_word(osc_source_config_word),
	.osc_ctrl(osc_ctrl), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
	.instr_clk_en(instr_clk_en), .primary_osc_out_pin_oe_n(primary_osc_out_pin_oe_n)
);

// file: tb/scs_clock_select_bench.sv
module scs_clock_select_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import scs_pkg::*;
	logic          pclk = 1'b0;
	logic          presetn = 1'b0;
	logic          psel = 1'b0;
	logic          penable = 1'b0;
	logic          pwrite = 1'b0;
	logic [7:0]    paddr = 8'h00;
	logic [31:0]   pwdata = 32'h0;
	logic [31:0]   prdata;
	logic          pready;
	logic          pslverr;
	logic [12:0]   cfg = 13'h1fff;
	logic          pri_pin;
	logic          sec_pin;
	logic          pin_o;
	logic          pin_oe_n;
	scs_osc_ctrl_t osc_ctrl;
	logic          cpu_en;
	logic          periph_en;
	logic          instr_en;
	logic [31:0]   rd;
	logic          err;
	int            n_mismatch = 0;
	int            num_checks = 0;
	int            cycles = 0;
	logic [31:0]   n_cpu;
	logic [31:0]   n_instr;
	logic [31:0]   n_pin;

	always #2 pclk = ~pclk;

	scs_clock_select dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_source_config_word(cfg),
		.primary_osc_in_pin(pri_pin), .secondary_osc_in_pin(sec_pin), .primary_osc_out_pin_o(pin_o),
		.primary_osc_out_pin_oe_n(pin_oe_n), .osc_ctrl(osc_ctrl), .cpu_clk_en(cpu_en),
		.periph_clk_en(periph_en), .instr_clk_en(instr_en)
	);
	scs_osc_model pri_u (.pin(pri_pin));
	scs_osc_model #(.HALF_NS(44)) sec_u (.pin(sec_pin));

	// ------------
	// Helpers
	// ------------
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			results();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench timeout ends a wait that never sees pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Config is only taken after reset, so each setup needs a fresh reset
	task automatic boot(input logic [12:0] w);
		@(posedge pclk);
		presetn <= 1'b0;
		cfg <= w;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (10) @(posedge pclk);
	endtask

	task automatic count(input int n);
		n_cpu = 0;
		n_instr = 0;
		n_pin = 0;
		repeat (n) begin
			@(posedge pclk);
			// Four-state sums so an unknown enable spoils the count
			n_cpu += {31'h0, cpu_en};
			n_instr += {31'h0, instr_en};
			n_pin += {31'h0, pin_o};
		end
	endtask

	function automatic logic [12:0] mk(input logic [2:0] i, input logic [1:0] p, input logic [1:0] s, input logic o);
		return {1'b1, o, i, s, 1'b1, 2'h3, 1'b1, p};
	endfunction

	// ------------
	// Scenarios
	// ------------
	task automatic t_power_on();
		boot(13'h1fff);
		apb(1'b0, SCS_ADDR_STATUS, 32'h0);
		chk(rd[7:0], {4'h0, SCS_SRC_FRC_DIV});
		apb(1'b0, SCS_ADDR_CONFIG, 32'h0);
		chk(rd, 32'h0fff);
		count(32);
		chk(n_cpu, 32);
		chk(n_instr, 16);
		chk(pin_oe_n, 1'b1);
	endtask

	task automatic t_table();
		logic [8:0] tbl [12];
		tbl = '{{3'h7, 2'h3, SCS_SRC_FRC_DIV}, {3'h6, 2'h3, SCS_SRC_SLOW_FRC}, {3'h5, 2'h3, SCS_SRC_LOW_POWER_INTERNAL_RC},
			{3'h1, 2'h3, SCS_SRC_FRC_PLL}, {3'h0, 2'h3, SCS_SRC_FRC}, {3'h4, 2'h0, SCS_SRC_SEC},
			{3'h3, 2'h2, SCS_SRC_HS_PLL}, {3'h3, 2'h0, SCS_SRC_EXT_PLL}, {3'h2, 2'h2, SCS_SRC_HS},
			{3'h2, 2'h1, SCS_SRC_STD}, {3'h2, 2'h0, SCS_SRC_EXT}, {3'h3, 2'h1, SCS_SRC_FRC}};
		foreach (tbl[n]) begin
			boot(mk(tbl[n][8:6], tbl[n][5:4], 2'h3, 1'b1));
			apb(1'b0, SCS_ADDR_SWITCH, 32'h0);
			chk(rd[3:0], tbl[n][3:0]);
			chk(osc_ctrl.pll_enable, tbl[n][3:0] inside {SCS_SRC_FRC_PLL, SCS_SRC_HS_PLL, SCS_SRC_EXT_PLL});
			chk(osc_ctrl.slow_fast_rc_enable, tbl[n][3:0] == SCS_SRC_SLOW_FRC);
		end
	endtask

	task automatic t_rates();
		boot(13'h0250);
		apb(1'b0, SCS_ADDR_CONFIG, 32'h0);
		chk(rd, 32'h0148);
		count(64);
		chk(n_cpu >= 7 && n_cpu <= 9, 1'b1);
		chk(n_instr * 2 >= n_cpu - 1 && n_instr * 2 <= n_cpu + 1, 1'b1);
		chk(pin_oe_n, 1'b0);
		chk(n_pin > 0 && n_pin < 64, 1'b1);
		boot(mk(3'h3, 2'h0, 2'h3, 1'b1));
		count(64);
		chk(n_cpu >= 28 && n_cpu <= 36, 1'b1);
		chk(pin_oe_n, 1'b1);
		boot(mk(3'h2, 2'h2, 2'h3, 1'b0));
		chk(pin_oe_n, 1'b1);
		// Secondary pin period is 22 pclk cycles
		boot(mk(3'h4, 2'h0, 2'h3, 1'b1));
		count(64);
		chk(n_cpu >= 2 && n_cpu <= 3, 1'b1);
		chk({osc_ctrl.secondary_osc_enable, osc_ctrl.secondary_power_select}, 2'h3);
	endtask

	task automatic t_divider();
		boot(13'h1fff);
		apb(1'b1, SCS_ADDR_DIVIDER, 32'h1);
		apb(1'b0, SCS_ADDR_DIVIDER, 32'h0);
		chk(rd, 32'h1);
		chk(osc_ctrl.postdiv, 3'h1);
		count(32);
		chk(n_cpu, 16);
		apb(1'b1, 8'h10, 32'hff);
		chk(err, 1'b1);
		apb(1'b0, 8'h10, 32'h0);
		chk({err, rd}, {1'b1, 32'h0});
	endtask

	task automatic t_switch();
		boot(mk(3'h7, 2'h3, 2'h0, 1'b1));
		apb(1'b0, SCS_ADDR_STATUS, 32'h0);
		chk(rd[7:4], 4'h6);
		apb(1'b1, SCS_ADDR_SWITCH, 32'h300);
		apb(1'b0, SCS_ADDR_SWITCH, 32'h0);
		chk(rd[3:0], SCS_SRC_FRC);
		boot(mk(3'h7, 2'h3, 2'h2, 1'b1));
		apb(1'b1, SCS_ADDR_SWITCH, 32'h300);
		apb(1'b0, SCS_ADDR_STATUS, 32'h0);
		chk(rd[7:0], {4'h8, SCS_SRC_FRC_DIV});
		boot(mk(3'h7, 2'h3, 2'h1, 1'b1));
		apb(1'b0, SCS_ADDR_STATUS, 32'h0);
		chk(rd[7:4], 4'h2);
	endtask

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_power_on();
		t_table();
		t_rates();
		t_divider();
		t_switch();
		results();
	end
endmodule
